// ===== hw/arb_pkg.sv
`default_nettype none
package arb_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [6:0] OFS_GCTL  = 7'h00;
	localparam logic [6:0] OFS_GSTAT = 7'h04;
	localparam logic [6:0] OFS_JTAG  = 7'h08;
	localparam logic [6:0] OFS_REFCT = 7'h0C;
	localparam logic [6:0] OFS_RXCTL = 7'h20;
	localparam logic [6:0] OFS_RXSTA = 7'h24;
	localparam logic [6:0] OFS_FILL  = 7'h38;
	localparam logic [6:0] OFS_DIAG  = 7'h3C;
	localparam logic [6:0] OFS_LBDAT = 7'h40;
	localparam logic [6:0] OFS_VALID = 7'h50;
	localparam logic [6:0] OFS_VIOL  = 7'h54;
	localparam logic [6:0] OFS_QWIN  = 7'h60;
	// ==========================================
	// Field positions
	localparam int B_PE = 0, B_PRE = 1, B_SRST = 2, B_TIEN = 4;
	localparam int B_KIND = 16, B_LOVR = 24, B_LGRN = 25, B_LRED = 26;
	localparam int B_FWLV = 8, B_TIPD = 4;
	localparam int B_TRST = 0, B_TDO = 1, B_TMS = 2, B_TCK = 3, B_TDI = 4;
	localparam int B_PSEL = 5;
	localparam int B_MODE = 0, B_POL = 2, B_RUN = 5, B_STMP = 7;
	localparam int B_OVIE = 9, B_SYIE = 10, B_RLOV = 19, B_RLG = 20;
	localparam int B_RLR = 21, B_FLSH = 22, B_CRST = 23;
	localparam int B_PLEN = 0, B_MSZ = 4, B_OVF = 9, B_SYF = 10;
	localparam int B_CD = 14, B_LCK = 15, B_ROK = 16, B_INV = 17;
	localparam int B_LB = 8, B_RAOV = 10, B_FULL = 11;
	// ==========================================
	// Reset values and timing
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam int          TICK_BITS  = 21;
	localparam logic [7:0]  KIND_CODE  = 8'h5A; // arbitrary value
	localparam logic [7:0]  FW_LEVEL   = 8'h01; // arbitrary value
	localparam logic [1:0]  FR_SHORT   = 2'h0;
	localparam logic [1:0]  FR_LONG    = 2'h1;
	localparam logic [1:0]  POL_AUTO   = 2'h0;
	localparam logic [1:0]  POL_NORM   = 2'h1;
	localparam logic [1:0]  POL_INV    = 2'h2;

	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_STMP = 2'b01,
		ARB_DATA = 2'b11
	} arb_rx_state_t;

	typedef struct packed {
		logic       carrier_present;
		logic       link_locked;
		logic       input_rate_adequate;
		logic       input_inverted;
		logic [1:0] detected_packet_length;
		logic       code_violation;
		logic       sync_error;
	} arb_link_stat_t;

	typedef struct packed {
		logic       valid;
		logic       sop;
		logic [7:0] data;
	} arb_byte_t;
endpackage : arb_pkg
`default_nettype wire

// ===== hw/arb_regbank.sv
`default_nettype none
module arb_regbank #(
	parameter int QW   = 10,
	parameter int FILLW = 24,
	parameter logic [3:0] MEM_SIZE_CODE = 4'h3
) (
	input  wire logic                 mclk_i,
	input  wire logic                 arst_n_i,
	// Local bus of the host bridge
	input  wire logic                 lb_sel_i,
	input  wire logic                 lb_wr_i,
	input  wire logic                 lb_rd_i,
	input  wire logic [6:0]           lb_addr_i,
	input  wire logic [31:0]          lb_wdata_i,
	output logic      [31:0]          lb_rdata_o,
	output logic                      lb_ack_o,
	// Deserialiser side
	input  wire arb_pkg::arb_byte_t   rx_byte_i,
	input  wire arb_pkg::arb_link_stat_t link_stat_i,
	input  wire logic                 prom_tdo_i,
	// Pins and controls
	output logic                      eeprom_write_allow_o,
	output logic                      eeprom_protect_o,
	output logic                      soft_reset_o,
	output logic                      prom_trst_n_o,
	output logic                      prom_tms_o,
	output logic                      prom_tck_o,
	output logic                      prom_tdi_o,
	output logic                      prom_flash_select_o,
	output logic                      board_lamp_green_o,
	output logic                      board_lamp_red_o,
	output logic                      receive_lamp_green_o,
	output logic                      receive_lamp_red_o,
	output logic [1:0]                input_polarity_select_o,
	output logic [1:0]                receive_framing_select_o,
	output logic                      receive_channel_reset_o,
	output logic                      irq_o
);
	import arb_pkg::*;

	// Elaboration check: the fill field must hold a full queue count
	if (QW < 4 || QW > 24 || FILLW < QW + 1 || FILLW > 32) begin : g_bad_geom
		$error("arb_regbank: unsupported queue geometry");
	end

	// ==========================================
	// Pin synchronisers (external inputs)
	arb_link_stat_t st_s1_reg, st_reg;
	arb_byte_t      by_s1_reg, by_reg;
	logic           tdo_s1_reg, tdo_reg;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_s1_reg  <= '0;
			st_reg     <= '0;
			by_s1_reg  <= '0;
			by_reg     <= '0;
			tdo_s1_reg <= 1'b0;
			tdo_reg    <= 1'b0;
		end else begin
			st_s1_reg  <= link_stat_i;
			st_reg     <= st_s1_reg;
			by_s1_reg  <= rx_byte_i;
			by_reg     <= by_s1_reg;
			tdo_s1_reg <= prom_tdo_i;
			tdo_reg    <= tdo_s1_reg;
		end
	end

	// ==========================================
	// Bus decode
	// window decode
	// Only whole-word strobes exist on this port, so no lanes are decoded
	// word access only
	logic wr, rd;
	assign wr = lb_sel_i & lb_wr_i;
	assign rd = lb_sel_i & lb_rd_i;
	logic in_qwin;
	assign in_qwin = (lb_addr_i[6:5] == OFS_QWIN[6:5]);

	logic [31:0] gctl_reg, jtag_reg, rxctl_reg, diag_reg;
	logic        tick_pd_reg, ovf_reg, syf_reg, srst_reg;
	logic        chan_rst;
	assign chan_rst = srst_reg | rxctl_reg[B_CRST];

	// ==========================================
	// Control registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gctl_reg <= RST_ZERO;
			jtag_reg <= RST_ZERO;
			diag_reg <= RST_ZERO;
		end else if (wr) begin
			if (lb_addr_i == OFS_GCTL) begin
				gctl_reg[B_PE]   <= lb_wdata_i[B_PE];
				gctl_reg[B_PRE]  <= lb_wdata_i[B_PRE];
				gctl_reg[B_TIEN] <= lb_wdata_i[B_TIEN];
				gctl_reg[B_LRED:B_LOVR] <= lb_wdata_i[B_LRED:B_LOVR];
			end
			if (lb_addr_i == OFS_JTAG) begin
				jtag_reg[B_TRST] <= lb_wdata_i[B_TRST];
				jtag_reg[B_TDI:B_TMS] <= lb_wdata_i[B_TDI:B_TMS];
				jtag_reg[B_PSEL] <= lb_wdata_i[B_PSEL];
			end
			if (lb_addr_i == OFS_DIAG)
				diag_reg[B_LB] <= lb_wdata_i[B_LB];
		end else if (srst_reg) begin
			gctl_reg[B_LOVR] <= 1'b0;
		end
	end

	// Soft reset is a one-cycle pulse; the bit never stores
	// soft reset pulse
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			srst_reg <= 1'b0;
		else
			srst_reg <= wr && lb_addr_i == OFS_GCTL && lb_wdata_i[B_SRST];
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rxctl_reg <= RST_ZERO;
		end else if (wr && lb_addr_i == OFS_RXCTL) begin
			rxctl_reg[1:0] <= lb_wdata_i[1:0];
			rxctl_reg[3:2] <= lb_wdata_i[3:2];
			// run select, bit 6 kept reserved
			rxctl_reg[B_RUN] <= lb_wdata_i[B_RUN];
			rxctl_reg[B_STMP] <= lb_wdata_i[B_STMP];
			rxctl_reg[B_SYIE:B_OVIE] <= lb_wdata_i[B_SYIE:B_OVIE];
			rxctl_reg[B_RLR:B_RLOV] <= lb_wdata_i[B_RLR:B_RLOV];
			rxctl_reg[B_CRST:B_FLSH] <= lb_wdata_i[B_CRST:B_FLSH];
		end else if (srst_reg) begin
			rxctl_reg[B_RUN] <= 1'b0;
		end
	end

	// ==========================================
	// Reference counter and periodic tick
	logic [31:0] ref_reg;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ref_reg <= RST_ZERO;
		else
			ref_reg <= ref_reg + 32'h0000_0001;
	end

	// Set wins over a simultaneous write-one clear
	// tick every 2^21
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tick_pd_reg <= 1'b0;
		else if (ref_reg[TICK_BITS-1:0] == '1)
			tick_pd_reg <= 1'b1;
		else if (wr && lb_addr_i == OFS_GSTAT && lb_wdata_i[B_TIPD])
			tick_pd_reg <= 1'b0;
	end

	// ==========================================
	// Receive queue
	localparam int QD = 1 << QW;
	logic [7:0]   q_mem [QD];
	logic [QW:0]  wp_reg, rp_reg;
	logic [QW:0]  cnt;
	assign cnt = wp_reg - rp_reg;
	logic [1:0]   st_ix_reg;
	arb_rx_state_t rs_reg;
	logic [31:0]  stamp_reg;
	logic [7:0]   held_reg;
	logic         push;
	logic [7:0]   push_d;
	logic         q_full, rd_pop;
	assign q_full = cnt[QW];
	assign rd_pop = rd & in_qwin & (cnt >= (QW+1)'(4));

	// Loopback writes replace the serial source
	// stamp prepended at packet start
	always_comb begin
		push   = 1'b0;
		push_d = 8'h00;
		if (diag_reg[B_LB]) begin
			push   = wr && lb_addr_i == OFS_LBDAT;
			push_d = lb_wdata_i[7:0];
		end else if (rs_reg == ARB_STMP) begin
			push   = 1'b1;
			push_d = stamp_reg[8*st_ix_reg +: 8];
		end else if (rxctl_reg[B_RUN] && by_reg.valid &&
			!(rxctl_reg[B_STMP] && by_reg.sop && rs_reg != ARB_DATA)) begin
			push   = 1'b1;
			push_d = by_reg.data;
		end
	end

	// Stamp bytes are inserted little-endian; the sync byte is then held
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rs_reg    <= ARB_IDLE;
			st_ix_reg <= 2'h0;
			stamp_reg <= RST_ZERO;
			held_reg  <= 8'h00;
		end else if (chan_rst) begin
			rs_reg    <= ARB_IDLE;
			st_ix_reg <= 2'h0;
		end else begin
			case (rs_reg)
				ARB_IDLE, ARB_DATA: begin
					if (rxctl_reg[B_STMP] && rxctl_reg[B_RUN] &&
						!diag_reg[B_LB] && by_reg.valid && by_reg.sop &&
						rs_reg == ARB_IDLE) begin
						stamp_reg <= ref_reg;
						held_reg  <= by_reg.data;
						rs_reg    <= ARB_STMP;
					end else if (rs_reg == ARB_DATA) begin
						rs_reg <= ARB_IDLE;
					end
				end
				ARB_STMP: begin
					st_ix_reg <= st_ix_reg + 2'h1;
					if (st_ix_reg == 2'h3)
						rs_reg <= ARB_DATA;
				end
				default: rs_reg <= ARB_IDLE;
			endcase
		end
	end

	// Held sync byte is written right after the stamp; a byte arriving
	// in that cycle is dropped, a known limit of this shallow path
	logic push_held;
	assign push_held = (rs_reg == ARB_DATA);

	logic ovf_ev;
	assign ovf_ev = (push | push_held) & q_full;

	always_ff @(posedge mclk_i) begin
		if ((push | push_held) && !q_full)
			q_mem[wp_reg[QW-1:0]] <= push_held ? held_reg : push_d;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else if (chan_rst || rxctl_reg[B_FLSH]) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if ((push | push_held) && !q_full)
				wp_reg <= wp_reg + (QW+1)'(1);
			if (rd_pop)
				rp_reg <= rp_reg + (QW+1)'(4);
		end
	end

	// ==========================================
	// Status flags and tallies
	// write-one clear, set wins
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovf_reg <= 1'b0;
			syf_reg <= 1'b0;
		end else begin
			if (ovf_ev)
				ovf_reg <= 1'b1;
			else if (srst_reg || (wr && lb_addr_i == OFS_RXSTA &&
				lb_wdata_i[B_OVF]))
				ovf_reg <= 1'b0;
			if (st_reg.sync_error)
				syf_reg <= 1'b1;
			else if (srst_reg || (wr && lb_addr_i == OFS_RXSTA &&
				lb_wdata_i[B_SYF]))
				syf_reg <= 1'b0;
		end
	end

	logic [31:0] valid_reg, viol_reg;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			valid_reg <= RST_ZERO;
			viol_reg  <= RST_ZERO;
		end else begin
			if (by_reg.valid)
				valid_reg <= valid_reg + 32'h0000_0001;
			if (st_reg.code_violation)
				viol_reg <= viol_reg + 32'h0000_0001;
		end
	end

	// ==========================================
	// Read mux
	logic [31:0] rmux;
	always_comb begin
		rmux = RST_ZERO;
		case (lb_addr_i)
			OFS_GCTL: begin
				rmux[B_PE]  = gctl_reg[B_PE];
				rmux[B_PRE] = gctl_reg[B_PRE];
				rmux[B_TIEN] = gctl_reg[B_TIEN];
				rmux[B_FWLV +: 8] = FW_LEVEL;
				rmux[B_KIND +: 8] = KIND_CODE;
				rmux[B_LRED:B_LOVR] = gctl_reg[B_LRED:B_LOVR];
			end
			OFS_GSTAT: rmux[B_TIPD] = tick_pd_reg;
			OFS_JTAG: begin
				rmux = jtag_reg;
				rmux[B_TDO] = tdo_reg;
			end
			OFS_REFCT: rmux = ref_reg;
			OFS_RXCTL: rmux = rxctl_reg;
			OFS_RXSTA: begin
				rmux[1:0] = st_reg.detected_packet_length;
				rmux[B_MSZ +: 4] = MEM_SIZE_CODE;
				rmux[B_OVF] = ovf_reg;
				rmux[B_SYF] = syf_reg;
				rmux[B_CD]  = st_reg.carrier_present;
				rmux[B_LCK] = st_reg.link_locked;
				rmux[B_ROK] = st_reg.input_rate_adequate;
				rmux[B_INV] = st_reg.input_inverted;
			end
			OFS_FILL: rmux[FILLW-1:0] = FILLW'(cnt);
			OFS_DIAG: begin
				rmux[B_LB]   = diag_reg[B_LB];
				rmux[B_RAOV] = ovf_reg;
				rmux[B_FULL] = q_full;
			end
			OFS_VALID: rmux = valid_reg;
			OFS_VIOL:  rmux = viol_reg;
			default: begin
				if (in_qwin)
					rmux = {q_mem[rp_reg[QW-1:0] + QW'(3)],
						q_mem[rp_reg[QW-1:0] + QW'(2)],
						q_mem[rp_reg[QW-1:0] + QW'(1)],
						q_mem[rp_reg[QW-1:0]]};
			end
		endcase
	end

	// ==========================================
	// Registered outputs
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lb_rdata_o <= RST_ZERO;
			lb_ack_o   <= 1'b0;
			eeprom_write_allow_o <= 1'b0;
			eeprom_protect_o     <= 1'b0;
			soft_reset_o         <= 1'b0;
			prom_trst_n_o        <= 1'b0;
			prom_tms_o           <= 1'b0;
			prom_tck_o           <= 1'b0;
			prom_tdi_o           <= 1'b0;
			prom_flash_select_o  <= 1'b0;
			board_lamp_green_o   <= 1'b0;
			board_lamp_red_o     <= 1'b0;
			receive_lamp_green_o <= 1'b0;
			receive_lamp_red_o   <= 1'b0;
			input_polarity_select_o  <= POL_AUTO;
			receive_framing_select_o <= FR_SHORT;
			receive_channel_reset_o  <= 1'b0;
			irq_o                <= 1'b0;
		end else begin
			lb_rdata_o <= rd ? rmux : RST_ZERO;
			lb_ack_o   <= wr | rd;
			eeprom_write_allow_o <= gctl_reg[B_PE];
			eeprom_protect_o     <= gctl_reg[B_PRE];
			soft_reset_o         <= srst_reg;
			prom_trst_n_o        <= jtag_reg[B_TRST];
			prom_tms_o           <= jtag_reg[B_TMS];
			prom_tck_o           <= jtag_reg[B_TCK];
			prom_tdi_o           <= jtag_reg[B_TDI];
			prom_flash_select_o  <= jtag_reg[B_PSEL];
			board_lamp_green_o <= gctl_reg[B_LOVR] ? gctl_reg[B_LGRN]
				: st_reg.link_locked;
			board_lamp_red_o   <= gctl_reg[B_LOVR] ? gctl_reg[B_LRED]
				: !st_reg.carrier_present;
			receive_lamp_green_o <= rxctl_reg[B_RLOV] ? rxctl_reg[B_RLG]
				: rxctl_reg[B_RUN];
			receive_lamp_red_o   <= rxctl_reg[B_RLOV] ? rxctl_reg[B_RLR]
				: ovf_reg | syf_reg;
			input_polarity_select_o  <= rxctl_reg[3:2];
			receive_framing_select_o <= rxctl_reg[1:0];
			receive_channel_reset_o  <= chan_rst;
			irq_o <= (tick_pd_reg & gctl_reg[B_TIEN]) |
				(ovf_reg & rxctl_reg[B_OVIE]) | (syf_reg & rxctl_reg[B_SYIE]);
		end
	end
endmodule : arb_regbank
`default_nettype wire

// ===== test/arb_deser_model.sv
`default_nettype none
module arb_deser_model
	import arb_pkg::*;
(
	input  wire logic          mclk_i,
	output var arb_byte_t      rx_byte_o,
	output var arb_link_stat_t link_stat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_byte_o   = '0;
		link_stat_o = '0;
	end
	// ==========================================
	// Byte stream; idle data is the inverse of the last byte
	task automatic send(input int n, input logic [7:0] d);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk_i);
			rx_byte_o = {1'b1, i == 0, d};
			d = d + 8'h01;
			// Line byte rate is far below the clock, so bytes come spaced
			@(negedge mclk_i);
			rx_byte_o = {2'b00, ~rx_byte_o.data};
			repeat (6) @(negedge mclk_i);
		end
	endtask : send
	// ==========================================
	// Status levels and one-cycle event pulses
	task automatic levels(input logic [5:0] l);
		@(negedge mclk_i);
		link_stat_o = {l, 2'b00};
	endtask : levels
	task automatic pulse(input logic sync);
		@(negedge mclk_i);
		link_stat_o.sync_error     = sync;
		link_stat_o.code_violation = !sync;
		@(negedge mclk_i);
		link_stat_o.sync_error     = 1'b0;
		link_stat_o.code_violation = 1'b0;
	endtask : pulse
endmodule : arb_deser_model
`default_nettype wire

// ===== test/arb_regbank_sva.sv
`default_nettype none
module arb_regbank_sva
	import arb_pkg::*;
#(
	parameter logic [3:0] MEM_SIZE_CODE = 4'h3
) (
	input wire logic        mclk_i,
	input wire logic        arst_n_i,
	input wire logic        lb_sel_i,
	input wire logic        lb_wr_i,
	input wire logic        lb_rd_i,
	input wire logic [6:0]  lb_addr_i,
	input wire logic [31:0] lb_wdata_i,
	input wire logic [31:0] lb_rdata_o,
	input wire logic        lb_ack_o,
	input wire logic        eeprom_write_allow_o,
	input wire logic        soft_reset_o,
	input wire logic        prom_tck_o,
	input wire logic        board_lamp_green_o,
	input wire logic [1:0]  input_polarity_select_o,
	input wire logic [1:0]  receive_framing_select_o,
	input wire logic        receive_channel_reset_o
);
	// ==========================================
	// Access decode
	wire logic acc = lb_sel_i & (lb_wr_i | lb_rd_i);
	wire logic rda = lb_sel_i & lb_rd_i;
	wire logic wg  = lb_sel_i & lb_wr_i & (lb_addr_i == OFS_GCTL);
	wire logic wj  = lb_sel_i & lb_wr_i & (lb_addr_i == OFS_JTAG);
	wire logic wc  = lb_sel_i & lb_wr_i & (lb_addr_i == OFS_RXCTL);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	// ==========================================
	// Bus answer
	// one ack each
	property p_ack_one; acc |=> lb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack missing");
	property p_ack_only; !acc |=> !lb_ack_o; endproperty
	a_ack_only: assert property (p_ack_only) else $error("stray ack");
	property p_hole; rda && lb_addr_i == 7'h10 |=> lb_rdata_o == 32'h0; endproperty
	a_hole: assert property (p_hole) else $error("hole not zero");
	property p_kind;
		rda && lb_addr_i == OFS_GCTL |=> lb_rdata_o[23:16] == KIND_CODE;
	endproperty
	a_kind: assert property (p_kind) else $error("kind code");
	property p_msz;
		rda && lb_addr_i == OFS_RXSTA |=> lb_rdata_o[7:4] == MEM_SIZE_CODE;
	endproperty
	a_msz: assert property (p_msz) else $error("size code");

	// ==========================================
	// Control outputs
	// Checked exactly two cycles on: the control register, then the output flop
	// single reset pulse
	property p_srst; wg && lb_wdata_i[2] |-> ##2 soft_reset_o ##1 !soft_reset_o;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse");
	property p_pe; wg |-> ##2 eeprom_write_allow_o == $past(lb_wdata_i[0], 2);
	endproperty
	a_pe: assert property (p_pe) else $error("eeprom enable");
	property p_tck; wj |-> ##2 prom_tck_o == $past(lb_wdata_i[3], 2); endproperty
	a_tck: assert property (p_tck) else $error("jtag clock");
	property p_lamp;
		wg && lb_wdata_i[24] && !lb_wdata_i[2]
			|-> ##2 board_lamp_green_o == $past(lb_wdata_i[25], 2);
	endproperty
	a_lamp: assert property (p_lamp) else $error("board lamp");
	property p_pol; wc |-> ##2 input_polarity_select_o == $past(lb_wdata_i[3:2], 2);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity");
	property p_frm;
		wc |-> ##2 {receive_channel_reset_o, receive_framing_select_o}
			== $past({lb_wdata_i[23], lb_wdata_i[1:0]}, 2);
	endproperty
	a_frm: assert property (p_frm) else $error("framing");
endmodule : arb_regbank_sva

bind arb_regbank arb_regbank_sva #(.MEM_SIZE_CODE(MEM_SIZE_CODE)) i_arb_sva (
	.mclk_i, .arst_n_i, .lb_sel_i, .lb_wr_i, .lb_rd_i, .lb_addr_i,
	.lb_wdata_i, .lb_rdata_o, .lb_ack_o, .eeprom_write_allow_o,
	.soft_reset_o, .prom_tck_o, .board_lamp_green_o,
	.input_polarity_select_o, .receive_framing_select_o,
	.receive_channel_reset_o
);
`default_nettype wire

// ===== test/testbench.sv
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import arb_pkg::*;
	localparam logic [3:0] MSZ = 4'h3;
	localparam logic [31:0] ID = {8'h00, KIND_CODE, FW_LEVEL, 8'h00};
	localparam logic [6:0]  HOLES [4] = '{7'h10, 7'h1C, 7'h44, 7'h5C};
	logic        mclk_i = 1'b0, arst_n_i = 1'b0, prom_tdo_i = 1'b0;
	logic        lb_sel_i = 1'b0, lb_wr_i = 1'b0, lb_rd_i = 1'b0;
	logic [6:0]  lb_addr_i = '0;
	logic [31:0] lb_wdata_i = '0, lb_rdata_o, last_rd, r, v0, v1;
	logic [31:0] lfsr_st = 32'h829DE336;
	logic        lb_ack_o, eeprom_write_allow_o, eeprom_protect_o, irq_o;
	logic        prom_trst_n_o, prom_tms_o, prom_tck_o, prom_tdi_o;
	logic        prom_flash_select_o, board_lamp_green_o, board_lamp_red_o;
	logic        receive_lamp_green_o, receive_lamp_red_o;
	logic [1:0]  input_polarity_select_o, receive_framing_select_o;
	logic [63:0] exp_q[$];
	logic [63:0] n;
	int          error_cnt = 0, checked = 0;
	arb_byte_t      rx_byte_i;
	arb_link_stat_t link_stat_i;

	arb_regbank #(.QW(10), .FILLW(24), .MEM_SIZE_CODE(MSZ)) i_arb_regbank (
		.mclk_i, .arst_n_i, .lb_sel_i, .lb_wr_i, .lb_rd_i, .lb_addr_i,
		.lb_wdata_i, .lb_rdata_o, .lb_ack_o, .rx_byte_i, .link_stat_i,
		.prom_tdo_i, .eeprom_write_allow_o, .eeprom_protect_o,
		.soft_reset_o(), .prom_trst_n_o, .prom_tms_o, .prom_tck_o,
		.prom_tdi_o, .prom_flash_select_o, .board_lamp_green_o,
		.board_lamp_red_o, .receive_lamp_green_o, .receive_lamp_red_o,
		.input_polarity_select_o, .receive_framing_select_o,
		.receive_channel_reset_o(), .irq_o
	);
	arb_deser_model i_arb_deser_model (
		.mclk_i, .rx_byte_o(rx_byte_i), .link_stat_o(link_stat_i)
	);

	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	// ==========================================
	// Host side: each access notes its expected read data
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic rnd();
		lfsr_st = lfsr_next(lfsr_st);
	endtask : rnd
	task automatic cyc(input int c);
		repeat (c) @(negedge mclk_i);
	endtask : cyc
	task automatic bus(input logic w, input logic [6:0] a,
			input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
		@(negedge mclk_i);
		lb_sel_i   = 1'b1;
		lb_wr_i    = w;
		lb_rd_i    = !w;
		lb_addr_i  = a;
		lb_wdata_i = d;
		exp_q.push_back({e & m, m});
		@(negedge mclk_i);
		lb_sel_i = 1'b0;
		lb_wr_i  = 1'b0;
		lb_rd_i  = 1'b0;
	endtask : bus
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [31:0] e,
			input logic [31:0] m);
		bus(1'b0, a, 32'h0, e, m);
	endtask : rd
	task automatic get(input logic [6:0] a, output logic [31:0] v);
		rd(a, 32'h0, 32'h0);
		@(posedge mclk_i);
		#1;
		v = last_rd;
	endtask : get
	// ==========================================
	// Answer monitor: one note per acknowledge
	// Falling edge, so the registered answer has settled
	always @(negedge mclk_i) begin
		if (lb_ack_o === 1'b1) begin
			last_rd = lb_rdata_o;
			if (exp_q.size() == 0) `CHK("ack", 1'b0, 1'b1)
			else begin
				n = exp_q.pop_front();
				`CHK("rdata", n[63:32], lb_rdata_o & n[31:0])
			end
		end
	end
	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Generous: the sequence needs a few hundred cycles
	initial begin
		#(4 * 40000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(negedge mclk_i);
		arst_n_i = 1'b1;
		rd(OFS_GCTL, ID, '1);
		for (int i = 0; i < 4; i++) begin
			rnd();
			r = (lfsr_st & 32'h0700_0003) | {7'h0, i[0], 24'h0};
			wr(OFS_GCTL, r | 32'hF8FF_FFE8);
			rd(OFS_GCTL, r | ID, '1);
			`CHK("pe", r[1:0], {eeprom_protect_o, eeprom_write_allow_o})
			if (r[24]) `CHK("lamp", r[26:25], {board_lamp_red_o, board_lamp_green_o})
			rnd();
			prom_tdo_i = lfsr_st[8];
			r = lfsr_st & 32'h0000_003D;
			wr(OFS_JTAG, r);
			cyc(3);
			rd(OFS_JTAG, {r[5:2], prom_tdo_i, r[0]}, 32'h3B);
			`CHK("jtag", r[5:0], {prom_flash_select_o, prom_tdi_o, prom_tck_o, prom_tms_o, 1'b0, prom_trst_n_o})
		end
		foreach (HOLES[k]) rd(HOLES[k], 32'h0, '1);
		for (int i = 0; i < 4; i++) begin
			rnd();
			r = (lfsr_st & 32'h0038_06A0) | (32'(i % 3) << 2) | 32'(i)
				| {12'h0, i[0], 19'h0};
			wr(OFS_RXCTL, r | 32'h0007_F950);
			rd(OFS_RXCTL, r, '1);
			`CHK("pol", r[3:0], {input_polarity_select_o, receive_framing_select_o})
			if (r[19]) `CHK("rxlamp", r[21:20], {receive_lamp_red_o, receive_lamp_green_o})
		end
		for (int i = 0; i < 3; i++) begin
			rnd();
			i_arb_deser_model.levels(lfsr_st[5:0]);
			cyc(4);
			rd(OFS_RXSTA, {14'h0, lfsr_st[2], lfsr_st[3], lfsr_st[4], lfsr_st[5], 6'h0, MSZ, 2'h0, lfsr_st[1:0]}, '1);
		end
		wr(OFS_RXCTL, 32'h0000_0020);
		i_arb_deser_model.pulse(1'b1);
		cyc(4);
		`CHK("irq", 1'b0, irq_o)
		rd(OFS_RXSTA, 32'h400, 32'h600);
		wr(OFS_RXCTL, 32'h0000_0420);
		cyc(3);
		`CHK("irq", 1'b1, irq_o)
		wr(OFS_RXSTA, 32'h400);
		cyc(3);
		rd(OFS_RXSTA, 32'h0, 32'h600);
		`CHK("irq", 1'b0, irq_o)
		i_arb_deser_model.pulse(1'b1);
		cyc(4);
		wr(OFS_GCTL, 32'h0000_0005);
		cyc(3);
		rd(OFS_GCTL, 32'h1, 32'h7);
		rd(OFS_RXCTL, 32'h400, 32'h420);
		rd(OFS_RXSTA, 32'h0, 32'h600);
		`CHK("lamp", {!lfsr_st[5], lfsr_st[4]}, {board_lamp_red_o, board_lamp_green_o})
		`CHK("rxlamp", 2'b00, {receive_lamp_red_o, receive_lamp_green_o})
		get(OFS_VALID, v0);
		get(OFS_VIOL, v1);
		wr(OFS_RXCTL, 32'h0000_00A0);
		i_arb_deser_model.send(10, 8'h47);
		for (int i = 0; i < 3; i++) i_arb_deser_model.pulse(1'b0);
		cyc(4);
		get(OFS_VALID, r);
		`CHK("valid", v0 + 32'd10, r)
		get(OFS_VIOL, r);
		`CHK("viol", v1 + 32'd3, r)
		rd(OFS_FILL, 32'd14, 32'h00FF_FFFF);
		rd(OFS_QWIN, 32'h0, 32'h0);
		rd(OFS_QWIN, 32'h4A49_4847, '1);
		rd(OFS_FILL, 32'd6, 32'h00FF_FFFF);
		wr(OFS_RXCTL, 32'h0040_0000);
		cyc(3);
		rd(OFS_FILL, 32'h0, '1);
		wr(OFS_RXCTL, 32'h0);
		wr(OFS_DIAG, 32'h100);
		rd(OFS_DIAG, 32'h100, 32'h100);
		rnd();
		for (int i = 0; i < 4; i++) wr(OFS_LBDAT, lfsr_st >> (8 * i));
		rd(OFS_FILL, 32'd4, 32'h00FF_FFFF);
		rd(7'h64, lfsr_st, '1);
		rd(OFS_FILL, 32'd0, 32'h00FF_FFFF);
		wr(OFS_LBDAT, 32'hFFFF_FFA5);
		rd(OFS_QWIN, 32'h0, 32'h0);
		rd(OFS_FILL, 32'd1, 32'h00FF_FFFF);
		wr(OFS_RXCTL, 32'h0080_0000);
		cyc(3);
		rd(OFS_FILL, 32'd0, 32'h00FF_FFFF);
		wr(OFS_RXCTL, 32'h0);
		get(OFS_REFCT, v0);
		repeat (100) @(posedge mclk_i);
		get(OFS_REFCT, v1);
		`CHK("refcnt", 32'd102, v1 - v0)
		cyc(3);
		`CHK("notes", 32'd0, 32'(exp_q.size()))
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
